// [hdl/timer8_wave_unit_regs.sv]
// Timer core, register slave on classic Wishbone and waveform output
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module timer8_wave_unit_regs
  import timer8_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic global_irq_enable_i, // Processor global enable
  input wire logic compare_irq_ack_i, // Compare vector entered
  input wire logic overflow_irq_ack_i, // Overflow vector entered
  input wire logic ext_count_pin_i, // External count pin, async
  input wire logic compare_out_dir_i, // Port direction bit for the pin
  output logic compare_irq_o, // Compare interrupt request
  output logic overflow_irq_o, // Overflow interrupt request
  output logic compare_out_pin_o, // Compare output pin value
  output logic compare_out_pin_oe_n_o, // Low while pin is driven
  output logic compare_out_override_o // Pin taken from port logic
);
  logic [7:0] control;
  logic [7:0] count;
  logic [7:0] compare;
  logic [7:0] compare_buf;
  logic [1:0] mask;
  logic [1:0] flags;
  logic counting_down;
  logic wave;
  logic block_match;
  logic [9:0] prescale;
  logic [2:0] ext_sync;
  logic ext_prev;
  logic ack;
  logic [31:0] rdata;
  logic [7:0] next_control;
  logic [7:0] next_count;
  logic [7:0] next_compare;
  logic [7:0] next_compare_buf;
  logic [1:0] next_mask;
  logic [1:0] next_flags;
  logic next_counting_down;
  logic next_wave;
  logic next_block_match;
  logic [9:0] next_prescale;
  logic [2:0] next_ext_sync;
  logic next_ext_prev;
  logic next_ack;
  logic [31:0] next_rdata;

  logic [1:0] mode;
  logic [1:0] action;
  logic [2:0] clk_sel;
  logic tick;
  logic ext_level;
  logic match;
  logic wr_req;
  logic rd_req;
  logic lane0;
  logic force_hit;

  // Word-aligned register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a[7:2] == r[7:2]);
  endfunction

  // Non-PWM reaction of the wave bit to a real or forced match
  function automatic logic act_on_match(input logic [1:0] act,
    input logic cur);
    case (act)
      2'h1: act_on_match = ~cur;
      2'h2: act_on_match = 1'b0;
      2'h3: act_on_match = 1'b1;
      default: act_on_match = cur;
    endcase
  endfunction

  assign mode = {control[BIT_WAVE_HIGH], control[BIT_WAVE_LOW]};
  assign action = control[BIT_ACTION_HI:BIT_ACTION_LO];
  assign clk_sel = control[BIT_CS_HI:0];
  assign wr_req = cyc_i & stb_i & we_i & ~ack;
  assign rd_req = cyc_i & stb_i & ~we_i & ~ack;
  assign lane0 = sel_i[0];
  // Stage 2 and 3 must agree before an edge is believed
  assign ext_level = (ext_sync[2] == ext_sync[1]) ? ext_sync[1] : ext_prev;
  // Compare logic sees the active (possibly buffered) value
  assign match = (count == compare_buf);
  assign force_hit = wr_req & lane0 & hit(adr_i, {4'h0, ADDR_CONTROL_A})
    & dat_i[BIT_FORCE] & ~mode[0];

  always_comb
  begin
    unique case (clk_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = ((prescale & DIV_8) == DIV_8);
      3'h3: tick = ((prescale & DIV_64) == DIV_64);
      3'h4: tick = ((prescale & DIV_256) == DIV_256);
      3'h5: tick = (prescale == DIV_1024);
      3'h6: tick = ext_prev & ~ext_level;
      3'h7: tick = ~ext_prev & ext_level;
      default: tick = 1'b0;
    endcase
  end

  // Prescaler and pin synchroniser run whatever the clock selection
  always_comb
  begin
    next_prescale = prescale + 10'h001;
    next_ext_sync = {ext_sync[1:0], ext_count_pin_i};
    next_ext_prev = ext_level;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescale <= 10'h000;
      ext_sync <= 3'h0;
      ext_prev <= 1'b0;
    end
    else
    begin
      prescale <= next_prescale;
      ext_sync <= next_ext_sync;
      ext_prev <= next_ext_prev;
    end
  end

  always_comb
  begin
    logic eff_match;
    logic top_hit;
    logic at_top;
    logic [7:0] top;
    // Flags raised by the counter this cycle; a clear write cannot undo them
    logic [1:0] hw_set;
    hw_set = 2'h0;
    eff_match = 1'b0;
    top_hit = 1'b0;
    at_top = 1'b0;
    top = COUNT_MAX;
    next_control = control;
    next_count = count;
    next_compare = compare;
    next_compare_buf = compare_buf;
    next_mask = mask;
    next_flags = flags;
    next_counting_down = counting_down;
    next_wave = wave;
    next_block_match = block_match;
    if (mode == MODE_CLEAR)
    begin
      top = compare_buf;
    end
    if (tick)
    begin
      // A software counter write blocks the match of the next tick after it
      eff_match = match & ~block_match;
      next_block_match = 1'b0;
      top_hit = (compare_buf == COUNT_MAX) & action[1];
      case (mode)
        MODE_NORMAL, MODE_CLEAR:
        begin
          next_count = (count == top) ? COUNT_BOTTOM : count + 8'h01;
          if (count == COUNT_MAX)
          begin
            hw_set[BIT_OVERFLOW] = 1'b1;
          end
          if (eff_match)
          begin
            next_wave = act_on_match(action, wave);
          end
        end
        MODE_FAST:
        begin
          next_count = count + 8'h01;
          if (count == COUNT_MAX)
          begin
            hw_set[BIT_OVERFLOW] = 1'b1;
            next_compare_buf = compare;
            if (action[1])
            begin
              next_wave = ~action[0];
            end
          end
          else if (eff_match && !top_hit && action[1])
          begin
            next_wave = action[0];
          end
        end
        MODE_PHASE:
        begin
          at_top = (count == COUNT_MAX);
          if (!counting_down)
          begin
            if (at_top)
            begin
              next_counting_down = 1'b1;
              next_count = count - 8'h01;
              next_compare_buf = compare;
            end
            else
            begin
              next_count = count + 8'h01;
            end
          end
          else if (count == COUNT_BOTTOM)
          begin
            next_counting_down = 1'b0;
            next_count = count + 8'h01;
            hw_set[BIT_OVERFLOW] = 1'b1;
          end
          else
          begin
            next_count = count - 8'h01;
          end
          if (action[1])
          begin
            if (top_hit && at_top)
            begin
              // At top the pin takes the down-count result, keeping symmetry
              next_wave = ~action[0];
            end
            else if (eff_match && !top_hit)
            begin
              next_wave = counting_down ? ~action[0] : action[0];
            end
          end
        end
        default: next_count = count;
      endcase
      if (eff_match)
      begin
        hw_set[BIT_COMPARE] = 1'b1;
      end
      next_flags = next_flags | hw_set;
    end
    if (mode == MODE_NORMAL || mode == MODE_CLEAR)
    begin
      next_compare_buf = next_compare;
    end
    if (force_hit)
    begin
      // Wave change only: no flag, no counter clear
      next_wave = act_on_match(action, wave);
    end
    if (compare_irq_ack_i)
    begin
      next_flags[BIT_COMPARE] = 1'b0;
    end
    if (overflow_irq_ack_i)
    begin
      next_flags[BIT_OVERFLOW] = 1'b0;
    end
    if (wr_req && lane0)
    begin
      if (hit(adr_i, {4'h0, ADDR_CONTROL_A}))
      begin
        next_control = {1'b0, dat_i[6:0]};
      end
      if (hit(adr_i, {4'h0, ADDR_COUNT}))
      begin
        next_count = dat_i[7:0];
        next_block_match = 1'b1;
      end
      if (hit(adr_i, {4'h0, ADDR_COMPARE_A}))
      begin
        next_compare = dat_i[7:0];
        if (mode == MODE_NORMAL || mode == MODE_CLEAR)
        begin
          next_compare_buf = dat_i[7:0];
        end
      end
      if (hit(adr_i, {4'h0, ADDR_IRQ_MASK}))
      begin
        next_mask = dat_i[1:0];
      end
      if (hit(adr_i, ADDR_FLAGS_BYTE))
      begin
        // A flag set by hardware in this cycle survives the clear
        next_flags = next_flags & ~(dat_i[1:0] & ~hw_set);
      end
    end
  end

  // Bus answer: one registered ack per request, read data beside it
  always_comb
  begin
    next_ack = cyc_i & stb_i & ~ack;
    next_rdata = rdata;
    // Unmapped addresses read as zero but are still acknowledged
    if (rd_req)
    begin
      next_rdata = 32'h0000_0000;
      if (hit(adr_i, {4'h0, ADDR_CONTROL_A}))
      begin
        next_rdata[7:0] = control & 8'h7f;
      end
      else if (hit(adr_i, {4'h0, ADDR_COUNT}))
      begin
        next_rdata[7:0] = count;
      end
      else if (hit(adr_i, {4'h0, ADDR_COMPARE_A}))
      begin
        next_rdata[7:0] = compare;
      end
      else if (hit(adr_i, {4'h0, ADDR_IRQ_MASK}))
      begin
        next_rdata[1:0] = mask;
      end
      else if (hit(adr_i, ADDR_FLAGS_BYTE))
      begin
        next_rdata[1:0] = flags;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control <= RESET_VALUE;
      count <= RESET_VALUE;
      compare <= RESET_VALUE;
      compare_buf <= RESET_VALUE;
      mask <= 2'h0;
      flags <= 2'h0;
      counting_down <= 1'b0;
      wave <= 1'b0;
      block_match <= 1'b0;
    end
    else
    begin
      control <= next_control;
      count <= next_count;
      compare <= next_compare;
      compare_buf <= next_compare_buf;
      mask <= next_mask;
      flags <= next_flags;
      counting_down <= next_counting_down;
      wave <= next_wave;
      block_match <= next_block_match;
    end
  end

  // Ack falls by itself next cycle; a request still held then is acknowledged again
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;
  assign compare_irq_o = mask[BIT_COMPARE] & global_irq_enable_i
    & flags[BIT_COMPARE];
  assign overflow_irq_o = mask[BIT_OVERFLOW] & global_irq_enable_i
    & flags[BIT_OVERFLOW];
  assign compare_out_override_o = (action != 2'h0);
  assign compare_out_pin_o = wave;
  assign compare_out_pin_oe_n_o = ~((action != 2'h0) & compare_out_dir_i);
endmodule

// [shared/timer8_pkg.sv]
// Constants for the 8-bit timer with one compare channel
// How it works
// - Writing one to force_compare_strobe in non-PWM modes forces a compare match.
// - A forced match sets no flag, requests no interrupt, never clears counter.
// - force_compare_strobe always reads back as zero.
// - wave_mode_sel picks normal, phase-correct, clear-on-match or fast PWM, and top.
// - Compare update timing and overflow flag point depend on the wave mode.
// - Nonzero compare_out_action routes the compare output to the pin.
// - Non-PWM actions: disconnect, toggle, clear or set on match.
// - Fast PWM actions: disconnect, reserved, clear/set on match, opposite at bottom.
// - Fast PWM, compare equals top, upper bit set: match ignored, bottom action kept.
// - Phase-correct actions: clear/set on up match, opposite on down match.
// - Phase-correct, compare equals top, upper bit set: act at top instead.
// - clock_source_sel: stop, divide 1/8/64/256/1024, external falling or rising.
// - External edges count even when the count pin is an output.
// - Counter is read/write; a write blocks the compare match next tick.
// - Compare value checked against counter every tick; match drives flag and wave.
// - Compare interrupt needs enable, global enable and compare flag.
// - Overflow interrupt needs enable, global enable and overflow flag.
// - Compare flag set on match, cleared by vector entry or writing one.
// - Overflow flag set on overflow, cleared by vector entry or writing one.
// - Phase-correct sets the overflow flag on reversing at zero.
// - Fast PWM counts zero to max and restarts from zero.
// - Phase-correct counts up then down, holding max one tick.
package timer8_pkg;
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h0 + 4'h0;
  localparam logic [7:0] ADDR_FLAGS_BYTE = 8'h10;
  localparam int BIT_FORCE = 7;
  localparam int BIT_WAVE_HIGH = 6;
  localparam int BIT_ACTION_HI = 5;
  localparam int BIT_ACTION_LO = 4;
  localparam int BIT_WAVE_LOW = 3;
  localparam int BIT_CS_HI = 2;
  localparam int BIT_COMPARE = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_64 = 10'h03f;
  localparam logic [9:0] DIV_256 = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
endpackage

// [tb/cpu_vector_model.sv]
// Processor side: enters the timer's interrupt vectors
`timescale 1ns/1ps
module cpu_vector_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic auto_i, // Take vectors when set
  input wire logic [3:0] delay_i, // Cycles before vector entry
  input wire logic cmp_irq_i, // Compare request
  input wire logic ovf_irq_i, // Overflow request
  output logic cmp_ack_o, // Compare vector entered
  output logic ovf_ack_o // Overflow vector entered
);
  logic [3:0] wait_cnt;
  // Compare first; a pending overflow is taken on the next entry
  always_ff @(posedge clk_i)
  begin
    cmp_ack_o <= 1'b0;
    ovf_ack_o <= 1'b0;
    if (rst_i || !auto_i || !(cmp_irq_i || ovf_irq_i) || cmp_ack_o ||
        ovf_ack_o)
      wait_cnt <= 4'h0;
    else if (wait_cnt == delay_i)
    begin
      cmp_ack_o <= cmp_irq_i;
      ovf_ack_o <= !cmp_irq_i;
      wait_cnt <= 4'h0;
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [tb/test_timer8_wave_unit_regs.sv]
// Bench for the 8-bit timer: registers, forced compare, flags, clocking
`timescale 1ns/1ps
module test_timer8_wave_unit_regs;
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, v;
  logic [3:0] sel_i = 4'h0, dly = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd_data, exp_v, expq[$];
  logic ack_o, global_irq_enable_i = 1'b0, ext_count_pin_i = 1'b0;
  logic compare_out_dir_i = 1'b0, compare_irq_o, overflow_irq_o;
  logic compare_out_pin_o, compare_out_pin_oe_n_o, compare_out_override_o;
  logic compare_irq_ack_i, overflow_irq_ack_i, auto = 1'b0, chk_now = 1'b0;
  logic [1:0] act_tab[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  // A forced match acts with the action that stood before the same write
  logic pin_tab[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int div_tab[4] = '{8, 64, 256, 1024};
  int n_fail = 0, tests_run = 0, hi;
  timer8_wave_unit_regs dut (.*);
  cpu_vector_model cpu (.clk_i, .rst_i, .auto_i(auto), .delay_i(dly),
    .cmp_irq_i(compare_irq_o), .ovf_irq_i(overflow_irq_o),
    .cmp_ack_o(compare_irq_ack_i), .ovf_ack_o(overflow_irq_ack_i));
  always #5 clk_i = ~clk_i;
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd_data = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic c, input logic [7:0] e);
    if (c) expq.push_back({24'h0, e});
    chk_now = c;
    bus(1'b0, a, 8'h00);
  endtask
  task automatic stop_test;
    $display("counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reads are judged here, oldest expectation first
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0 && chk_now)
    begin
      exp_v = expq.pop_front();
      `CHK("read data", exp_v, dat_o)
    end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'h4ef75474));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 6; a++) rd(8'(a * 4), 1'b1, 8'h00);
    v = 8'($urandom());
    bus(1'b1, 8'h08, v);
    rd(8'h08, 1'b1, v);
    bus(1'b1, 8'h0c, 8'h03);
    rd(8'h0c, 1'b1, 8'h03);
    bus(1'b1, 8'h04, v ^ 8'h5a);
    rd(8'h04, 1'b1, v ^ 8'h5a);
    $display("test registers done");
    compare_out_dir_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h00, {2'b10, act_tab[i], 4'h0});
      repeat (2) @(posedge clk_i);
      `CHK("pin", pin_tab[i], compare_out_pin_o)
    end
    rd(8'h00, 1'b1, 8'h10);
    bus(1'b1, 8'h00, 8'hd0);
    `CHK("pin", 1'b0, compare_out_pin_o)
    rd(8'h04, 1'b1, v ^ 8'h5a);
    rd(8'h10, 1'b1, 8'h00);
    $display("test forced compare done");
    global_irq_enable_i <= 1'b1;
    bus(1'b1, 8'h08, 8'h80);
    bus(1'b1, 8'h04, 8'hfd);
    bus(1'b1, 8'h00, 8'h01);
    repeat (8) @(posedge clk_i);
    `CHK("ovf irq", 1'b1, overflow_irq_o)
    bus(1'b1, 8'h10, 8'h00);
    rd(8'h10, 1'b1, 8'h01);
    bus(1'b1, 8'h10, 8'h01);
    rd(8'h10, 1'b1, 8'h00);
    repeat (150) @(posedge clk_i);
    `CHK("cmp irq", 1'b1, compare_irq_o)
    global_irq_enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("cmp irq off", 1'b0, compare_irq_o)
    global_irq_enable_i <= 1'b1;
    dly <= 4'($urandom() % 8);
    auto <= 1'b1;
    repeat (300) @(posedge clk_i);
    bus(1'b1, 8'h00, 8'h00);
    repeat (10) @(posedge clk_i);
    rd(8'h10, 1'b1, 8'h00);
    auto <= 1'b0;
    $display("test interrupts done");
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h04, 8'h00);
      bus(1'b1, 8'h00, 8'(k + 2));
      repeat (4 * div_tab[k]) @(posedge clk_i);
      bus(1'b1, 8'h00, 8'h00);
      rd(8'h04, 1'b0, 8'h00);
      `CHK("div", 1'b1, rd_data[7:0] inside {8'h04, 8'h05})
    end
    for (int k = 6; k < 8; k++)
    begin
      bus(1'b1, 8'h04, 8'h00);
      bus(1'b1, 8'h00, 8'(k));
      repeat (5)
      begin
        ext_count_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_count_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      repeat (6) @(posedge clk_i);
      bus(1'b1, 8'h00, 8'h00);
      rd(8'h04, 1'b1, 8'h05);
    end
    $display("test clock select done");
    bus(1'b1, 8'h08, 8'h40);
    bus(1'b1, 8'h00, 8'h41);
    repeat (300) @(posedge clk_i);
    rd(8'h04, 1'b0, 8'h00);
    `CHK("top", 1'b1, rd_data[7:0] <= 8'h40)
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, 8'h00, m ? 8'h29 : 8'h69);
      repeat (300) @(posedge clk_i);
      hi = 0;
      repeat (510) @(posedge clk_i) hi += compare_out_pin_o;
      `CHK("duty", 1'b1, hi inside {[124:134]})
    end
    $display("test waveforms done");
    stop_test;
  end
endmodule
bind timer8_wave_unit_regs timer8_checker_sva chk (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .global_irq_enable_i,
  .compare_irq_ack_i, .overflow_irq_ack_i, .compare_out_dir_i,
  .compare_irq_o, .overflow_irq_o, .compare_out_pin_o,
  .compare_out_pin_oe_n_o, .compare_out_override_o);

// [tb/timer8_checker_sva.sv]
// Checker on the timer's bus, interrupt and pin outputs
`timescale 1ns/1ps
module timer8_checker_sva (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Bus strobe
  input wire logic we_i, // Bus write
  input wire logic [7:0] adr_i, // Bus address
  input wire logic [31:0] dat_o, // Read data
  input wire logic ack_o, // Bus acknowledge
  input wire logic global_irq_enable_i, // Global enable
  input wire logic compare_irq_ack_i, // Compare vector taken
  input wire logic overflow_irq_ack_i, // Overflow vector taken
  input wire logic compare_out_dir_i, // Pin direction
  input wire logic compare_irq_o, // Compare request
  input wire logic overflow_irq_o, // Overflow request
  input wire logic compare_out_pin_o, // Wave bit
  input wire logic compare_out_pin_oe_n_o, // Pin drive, low active
  input wire logic compare_out_override_o // Pin taken over
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse after a request");
  a_cmp_irq_gate: assert property (
    !global_irq_enable_i |-> !compare_irq_o)
    else $error("compare request without global enable");
  a_ovf_irq_gate: assert property (
    !global_irq_enable_i |-> !overflow_irq_o)
    else $error("overflow request without global enable");
  a_cmp_ack_clear: assert property (
    compare_irq_ack_i |=> !compare_irq_o)
    else $error("compare request kept after vector entry");
  a_ovf_ack_clear: assert property (
    overflow_irq_ack_i |=> !overflow_irq_o)
    else $error("overflow request kept after vector entry");
  a_pin_drive_en: assert property (
    compare_out_pin_oe_n_o == !(compare_out_override_o && compare_out_dir_i))
    else $error("pin drive enable wrong");
  a_reset_quiet: assert property (
    $past(rst_i) |-> !compare_out_override_o && !compare_out_pin_o)
    else $error("pin not idle after reset");
  a_force_reads_zero: assert property (
    ack_o && !we_i && adr_i == 8'h00 |-> !dat_o[7])
    else $error("force strobe read back as one");
endmodule
